// ---- verilog/lbr_params.svh ----
// Constant definitions for the last branch recorder.
// Function
// - Stack control register at address 01D9H.
// - Record enable logs branches until debug exception.
// - Bit 1 makes single-step act on jumps.
// - Select bits pulse report pins on breakpoints.
// - Clear select bits report performance events instead.
// - Bit 6 emits each record as message.
// - Single registers undefined while messages enabled.
// - Bit 7 also stores messages to memory.
// - Bit 8 interrupts on full, else wraps.
// - Eight stack entries at addresses 040H-047H.
// - Entry: source low word, target high.
// - Top pointer bits 2-0 select newest.
// - Top pointer register at address 01C9H.
// - Single control writable only when privileged.
// - Debug exception clears single record enable.
// - Four single-record address registers, 32 bits.
// - Taken jump loads source and target.
// - Fault loads interrupted and handler addresses.
// - Fault first copies last pair to pre-fault.
// - Single registers hold offsets, readable.
// - Identification feature bit 21 reports store.
// - Top pointer increments before write, wraps.
// - Debug exception leaves recorded addresses untouched.
`ifndef LBR_PARAMS_SVH
`define LBR_PARAMS_SVH
`define ADDR_RECORD_BASE   12'h040
`define ADDR_RECORD_LAST   12'h047
`define ADDR_TOP_POINTER   12'h1C9
`define ADDR_CTL_STACK     12'h1D9
`define ADDR_CTL_SINGLE    12'h1E0
`define ADDR_JUMP_SRC      12'h1E1
`define ADDR_JUMP_DST      12'h1E2
`define ADDR_FAULT_SRC     12'h1E3
`define ADDR_FAULT_DST     12'h1E4
`define BIT_RECORD_EN      0
`define BIT_STEP_JUMP      1
`define PIN_SEL_LO         2
`define PIN_SEL_HI         5
`define BIT_MSG_EN         6
`define BIT_STORE_EN       7
`define BIT_STORE_IRQ      8
`define CTL_RESET          9'h000
`define CTL_WIDTH          9
`define FEATURE_STORE_BIT  21
`define FEATURE_RESET      32'h0020_0000
`endif

// ---- verilog/lbr_pkg.sv ----
// Types shared by the last branch recorder.
package lbr_pkg;
  // One observed control transfer from the pipeline.
  typedef struct packed {
    logic        valid;    // Transfer retired this cycle.
    logic        is_fault; // Interrupt or non-debug exception.
    logic [31:0] source;   // Address transferred from.
    logic [31:0] target;   // Address transferred to.
  } jump_event_t;
  // One model-specific register access.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [63:0] wdata;
  } reg_req_t;
  // Record placed on the trace message and store outputs.
  typedef struct packed {
    logic [31:0] target;
    logic [31:0] source;
  } jump_record_t;
endpackage : lbr_pkg

// ---- verilog/last_branch_recorder.sv ----
// Last branch, interrupt and exception recorder.
`timescale 1ns/1ps
`default_nettype none
`include "lbr_params.svh"
module last_branch_recorder
  import lbr_pkg::*;
(
  input  wire logic         core_clk_in,     // Core clock.
  input  wire logic         nrst_in,         // Core reset.
  input  wire jump_event_t  jump_in,         // Retired transfer.
  input  wire logic         debug_exc_in,    // Debug exception.
  input  wire logic [3:0]   bp_match_in,     // Breakpoint matches.
  input  wire logic [3:0]   perf_event_in,   // Performance events.
  input  wire logic         store_full_in,   // Store buffer full.
  input  wire logic         priv_ok_in,      // Level 0 or real mode.
  input  wire reg_req_t     req_in,          // Register access.
  output logic [63:0]       rdata_out,       // Read data.
  output logic              ack_out,         // Access done.
  output logic              fault_out,       // Access refused.
  output logic              step_on_jump_out,
  output logic [3:0]        report_pin_n_out,
  output logic              msg_valid_out,
  output jump_record_t      msg_out,
  output logic              store_valid_out,
  output jump_record_t      store_out,
  output logic              store_irq_out,
  output logic              store_wrap_out,
  output logic [31:0]       feature_out
);

  // Control registers, stack and single-record pairs.
  logic [`CTL_WIDTH-1:0] ctl_stack;   // Stack variant control.
  logic [`CTL_WIDTH-1:0] ctl_single;  // Single variant control.
  logic [2:0]            top;         // Newest stack entry.
  logic [63:0]           stack [8];   // Record stack.
  logic [31:0]           jump_src;    // Last jump source.
  logic [31:0]           jump_dst;    // Last jump target.
  logic [31:0]           fault_src;   // Pre-fault source.
  logic [31:0]           fault_dst;   // Pre-fault target.
  logic [`CTL_WIDTH-1:0] ctl_any;     // Union of both controls.
  logic                  take;        // Transfer to record.
  logic [2:0]            next_top;    // Pointer after a record.
  logic                  hit_stack;   // Address is a stack entry.
  logic                  wr_ok;       // Write accepted.

  // A debug exception itself is never a recorded transfer.
  assign take     = jump_in.valid && !debug_exc_in;
  assign ctl_any  = ctl_stack | ctl_single;
  assign next_top = top + 3'h1;
  assign hit_stack = req_in.addr >= `ADDR_RECORD_BASE &&
                     req_in.addr <= `ADDR_RECORD_LAST;

  // Writes to the single control need privilege; the stack control is open, all other writes are refused.
  always_comb begin
    wr_ok = 1'b0;
    if (req_in.valid && req_in.write) begin
      if (req_in.addr == `ADDR_CTL_STACK) begin
        wr_ok = 1'b1;
      end else if (req_in.addr == `ADDR_CTL_SINGLE) begin
        wr_ok = priv_ok_in;
      end
    end
  end

  // Stack control: written by software, enable cleared by debug trap.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_stack <= `CTL_RESET;
    end else begin
      if (wr_ok && req_in.addr == `ADDR_CTL_STACK) begin
        ctl_stack <= req_in.wdata[`CTL_WIDTH-1:0];
      end
      // The trap wins over a write in the same cycle.
      if (debug_exc_in) begin
        ctl_stack[`BIT_RECORD_EN] <= 1'b0;
      end
    end
  end

  // Single control: privileged write, enable cleared by debug trap.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_single <= `CTL_RESET;
    end else begin
      if (wr_ok && req_in.addr == `ADDR_CTL_SINGLE) begin
        ctl_single <= req_in.wdata[`CTL_WIDTH-1:0];
      end
      if (debug_exc_in) begin
        ctl_single[`BIT_RECORD_EN] <= 1'b0;
      end
    end
  end

  // Stack: advance the pointer, then fill the entry it names.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      top <= 3'h0;
      for (int i = 0; i < 8; i++) begin
        stack[i] <= 64'h0;
      end
    end else if (take && ctl_stack[`BIT_RECORD_EN]) begin
      top <= next_top;
      stack[next_top] <= {jump_in.target, jump_in.source};
    end
  end

  // Single-record pairs; a fault saves the old pair first.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      jump_src  <= 32'h0;
      jump_dst  <= 32'h0;
      fault_src <= 32'h0;
      fault_dst <= 32'h0;
    end else if (take && ctl_single[`BIT_RECORD_EN]) begin
      if (jump_in.is_fault) begin
        fault_src <= jump_src;
        fault_dst <= jump_dst;
      end
      // Pipeline supplies segment offsets here; values are undefined
      // to software while messages are enabled.
      jump_src <= jump_in.source;
      jump_dst <= jump_in.target;
    end
  end

  // Register reads answer one cycle after the request.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 64'h0;
      ack_out   <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      ack_out   <= req_in.valid;
      fault_out <= 1'b0;
      rdata_out <= 64'h0;
      if (req_in.valid && req_in.write) begin
        fault_out <= !wr_ok;
      end else if (req_in.valid) begin
        if (hit_stack) begin
          rdata_out <= stack[req_in.addr[2:0]];
        end else begin
          case (req_in.addr)
            `ADDR_TOP_POINTER: rdata_out <= {61'h0, top};
            `ADDR_CTL_STACK:   rdata_out <= {55'h0, ctl_stack};
            `ADDR_CTL_SINGLE:  rdata_out <= {55'h0, ctl_single};
            `ADDR_JUMP_SRC:    rdata_out <= {32'h0, jump_src};
            `ADDR_JUMP_DST:    rdata_out <= {32'h0, jump_dst};
            `ADDR_FAULT_SRC:   rdata_out <= {32'h0, fault_src};
            `ADDR_FAULT_DST:   rdata_out <= {32'h0, fault_dst};
            default:           fault_out <= 1'b1;
          endcase
        end
      end
    end
  end

  // Single-step mode flag handed to the pipeline.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_on_jump_out <= 1'b0;
    end else begin
      step_on_jump_out <= ctl_any[`BIT_STEP_JUMP];
    end
  end

  // Report pins: one low cycle per breakpoint or performance event.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      report_pin_n_out <= 4'hF;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ctl_any[`PIN_SEL_LO + i]) begin
          report_pin_n_out[i] <= !bp_match_in[i];
        end else begin
          report_pin_n_out[i] <= !perf_event_in[i];
        end
      end
    end
  end

  // Trace messages and memory store of each recorded transfer.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      msg_valid_out   <= 1'b0;
      msg_out         <= '0;
      store_valid_out <= 1'b0;
      store_out       <= '0;
    end else begin
      msg_valid_out   <= take && ctl_any[`BIT_MSG_EN];
      store_valid_out <= take && ctl_any[`BIT_MSG_EN] &&
                         ctl_any[`BIT_STORE_EN];
      if (take) begin
        msg_out   <= {jump_in.target, jump_in.source};
        store_out <= {jump_in.target, jump_in.source};
      end
    end
  end

  // Buffer full: interrupt, or tell the store engine to wrap.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      store_irq_out  <= 1'b0;
      store_wrap_out <= 1'b0;
    end else begin
      store_irq_out  <= store_full_in && ctl_any[`BIT_STORE_EN] &&
                        ctl_any[`BIT_STORE_IRQ];
      store_wrap_out <= store_full_in && ctl_any[`BIT_STORE_EN] &&
                        !ctl_any[`BIT_STORE_IRQ];
    end
  end

  // Identification feature word with the store capability bit.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      feature_out <= `FEATURE_RESET;
    end else begin
      feature_out <= `FEATURE_RESET;
    end
  end

  // Pointer moves by exactly one per recorded stack transfer.
  top_advance_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    take && ctl_stack[0] |=> top == $past(top) + 3'h1)
    else $error("top pointer did not advance");

  // New entry holds source low, target high.
  entry_layout_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    take && ctl_stack[0] |=> stack[top] ==
      {$past(jump_in.target), $past(jump_in.source)})
    else $error("stack entry layout wrong");

  // Debug trap clears both enables next cycle.
  trap_clear_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    debug_exc_in |=> !ctl_single[0] && !ctl_stack[0])
    else $error("enable survived debug trap");

  // Debug trap leaves stored addresses alone.
  trap_keep_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    debug_exc_in |=> $stable(jump_src) && $stable(fault_src)
      && $stable(top))
    else $error("trap altered records");

  // Fault copies the old last pair into the pre-fault pair.
  fault_copy_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    take && jump_in.is_fault && ctl_single[0] |=>
      fault_src == $past(jump_src) &&
      fault_dst == $past(jump_dst))
    else $error("pre-fault pair not copied");

  // Unprivileged single control write is refused and ignored.
  priv_write_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    req_in.valid && req_in.write && !priv_ok_in && !debug_exc_in
      && req_in.addr == `ADDR_CTL_SINGLE |=>
      fault_out && $stable(ctl_single))
    else $error("unprivileged write accepted");

  // Selected breakpoint match pulses its pin low then high.
  pin_pulse_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    ctl_any[2] && bp_match_in[0] ##1 !bp_match_in[0] |->
      !report_pin_n_out[0] ##1 report_pin_n_out[0])
    else $error("report pin not pulsed");

  // Message follows each transfer while messages are enabled.
  msg_emit_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    take && ctl_any[6] |=> msg_valid_out &&
      msg_out.source == $past(jump_in.source))
    else $error("trace message missing");

  // Full buffer yields interrupt or wrap, never both.
  store_full_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    store_full_in && ctl_any[7] |=>
      store_irq_out != store_wrap_out)
    else $error("store full handling wrong");

  // No message leaves while messages are disabled.
  msg_quiet_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    !ctl_any[`BIT_MSG_EN] |=> !msg_valid_out)
    else $error("message sent while disabled");

  // Store output follows each transfer when messages and store are on.
  store_emit_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    take && ctl_any[`BIT_MSG_EN] && ctl_any[`BIT_STORE_EN] |=>
      store_valid_out && store_out.target == $past(jump_in.target))
    else $error("store record missing");

  // Without the interrupt select a full buffer never interrupts.
  irq_off_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    !ctl_any[`BIT_STORE_IRQ] |=> !store_irq_out)
    else $error("store interrupt while disabled");

  // A transfer with stack recording off leaves the pointer alone.
  stack_idle_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    !ctl_stack[`BIT_RECORD_EN] |=> $stable(top))
    else $error("pointer moved while disabled");

  // The last pair takes source and target of each recorded transfer.
  pair_load_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    take && ctl_single[`BIT_RECORD_EN] |=>
      jump_src == $past(jump_in.source) &&
      jump_dst == $past(jump_in.target))
    else $error("last pair not loaded");

  // A stack entry read returns the entry named by the low bits.
  stack_read_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    req_in.valid && !req_in.write && hit_stack |=>
      ack_out && !fault_out &&
      rdata_out == $past(stack[req_in.addr[2:0]]))
    else $error("stack read wrong");

  // A pointer read returns the pointer in the low three bits.
  top_read_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    req_in.valid && !req_in.write &&
      req_in.addr == `ADDR_TOP_POINTER |=>
      !fault_out && rdata_out == {61'h0, $past(top)})
    else $error("pointer read wrong");

  // A stack control write lands unless a trap hits the same cycle.
  ctl_write_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    req_in.valid && req_in.write && !debug_exc_in &&
      req_in.addr == `ADDR_CTL_STACK |=>
      !fault_out && ctl_stack == $past(req_in.wdata[`CTL_WIDTH-1:0]))
    else $error("stack control write lost");

  // The step mode flag follows the control bit one cycle later.
  step_follow_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    1'b1 |=> step_on_jump_out == $past(ctl_any[`BIT_STEP_JUMP]))
    else $error("step mode flag stale");

  // An unselected pin shows the performance event instead.
  perf_pin_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    !ctl_any[`PIN_SEL_LO] |=>
      report_pin_n_out[0] == !$past(perf_event_in[0]))
    else $error("performance event not reported");

  // The store capability bit is always reported.
  feature_bit_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    feature_out[`FEATURE_STORE_BIT])
    else $error("store capability bit missing");

  // Every register request is answered exactly one cycle later.
  ack_follow_a: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in)
    1'b1 |=> ack_out == $past(req_in.valid))
    else $error("register answer out of step");

endmodule : last_branch_recorder
`default_nettype wire

// ---- sim/pipe_model.sv ----
// Pipeline model that retires one control transfer on request.
`timescale 1ns/1ps
`default_nettype none
module pipe_model
  import lbr_pkg::*;
(
  input  wire logic   clk_in,   // Core clock.
  input  wire logic   kick_in,  // Retire one transfer next edge.
  input  wire logic   fault_in, // The transfer is an interrupt or fault.
  output jump_event_t jump_out  // Transfer seen by the recorder.
);
  // Nothing is retired before the first kick.
  initial begin
    jump_out = '0;
  end
  // One retired transfer per kick, a one-cycle valid with fresh addresses.
  always @(posedge clk_in) begin
    if (kick_in) begin
      jump_out <= '{1'b1, fault_in, $urandom, $urandom};
    end else begin
      jump_out.valid <= 1'b0;
    end
  end
endmodule : pipe_model
`default_nettype wire

// ---- sim/last_branch_recorder_tb.sv ----
// Self-checking bench for the last branch recorder.
`timescale 1ns/1ps
`default_nettype none
module last_branch_recorder_tb
  import lbr_pkg::*;
;
  logic         clk = 0, nrst = 0, dbg = 0, full = 0, priv = 0;
  logic         kick = 0, kf = 0, ack, fault, step, msg_v, st_v, irq, wrap;
  logic [3:0]   bp = 0, perf = 0, pins, r;
  reg_req_t     req = '0;
  jump_event_t  jump;
  jump_record_t msg, st, sent, last;
  logic [63:0]  rdata, rd, stk [8];
  logic [31:0]  feature;
  logic [2:0]   top;
  logic         flt;
  int           errors = 0, compares = 0, cyc = 0;
  // The core clock, 50 ns period.
  always #25 clk = ~clk;
  pipe_model pipe_u (.clk_in(clk), .kick_in(kick), .fault_in(kf),
    .jump_out(jump));
  last_branch_recorder dut_u (.core_clk_in(clk), .nrst_in(nrst),
    .jump_in(jump), .debug_exc_in(dbg), .bp_match_in(bp),
    .perf_event_in(perf), .store_full_in(full), .priv_ok_in(priv),
    .req_in(req), .rdata_out(rdata), .ack_out(ack), .fault_out(fault),
    .step_on_jump_out(step), .report_pin_n_out(pins), .msg_valid_out(msg_v),
    .msg_out(msg), .store_valid_out(st_v), .store_out(st),
    .store_irq_out(irq), .store_wrap_out(wrap), .feature_out(feature));
  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // Compares one result with its expected value.
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One register access; the answer comes one cycle after it is taken.
  task acc(input logic w, input logic [11:0] a, input logic [63:0] d);
    @(posedge clk) req <= '{1'b1, w, a, d};
    @(posedge clk) req.valid <= 1'b0;
    #1 chk(ack, 1);
    rd = rdata;
    flt = fault;
  endtask : acc
  // One retired transfer; outputs are looked at in their answer cycle.
  task ev(input logic f);
    @(posedge clk) kick <= 1'b1;
    kf <= f;
    @(posedge clk) kick <= 1'b0;
    #1 sent = {jump.target, jump.source};
    @(posedge clk);
    #1;
  endtask : ev
  // A one-cycle store-full pulse, outputs checked after it lands.
  task full_pulse;
    @(posedge clk) full <= 1'b1;
    @(posedge clk) full <= 1'b0;
    #1;
  endtask : full_pulse
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test;
    end
  end
  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'h2c8812f7));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(feature, 32'h0020_0000);
    chk(pins, 4'hF);
    acc(0, 12'h1D9, 0); chk(rd, 0);
    acc(0, 12'h123, 0); chk(flt, 1);
    acc(1, 12'h040, '1); chk(flt, 1);
    // Single-record variant: refused without privilege, then recording.
    acc(1, 12'h1E0, 1); chk(flt, 1);
    acc(0, 12'h1E0, 0); chk(rd, 0);
    @(posedge clk) priv <= 1'b1;
    acc(1, 12'h1E0, 1); chk(flt, 0);
    ev(0);
    last = sent;
    acc(0, 12'h1E1, 0); chk(rd, {32'h0, last.source});
    ev(1);
    acc(0, 12'h1E2, 0); chk(rd, {32'h0, sent.target});
    acc(0, 12'h1E3, 0); chk(rd, {32'h0, last.source});
    acc(0, 12'h1E4, 0); chk(rd, {32'h0, last.target});
    // Stack variant: nine transfers wrap the top pointer.
    acc(1, 12'h1D9, 64'h1); chk(flt, 0);
    top = 0;
    repeat (9) begin
      ev(1'($urandom_range(1, 0)));
      top = top + 3'h1;
      stk[top] = sent;
      acc(0, 12'h1C9, 0); chk(rd, {61'h0, top});
    end
    for (int i = 0; i < 8; i++) begin
      acc(0, 12'(64 + i), 0); chk(rd, stk[i]);
    end
    // A debug exception stops recording and keeps the contents.
    last = sent;
    @(posedge clk) dbg <= 1'b1;
    @(posedge clk) dbg <= 1'b0;
    acc(0, 12'h1D9, 0); chk(rd, 0);
    acc(0, 12'h1E0, 0); chk(rd, 0);
    ev(0);
    chk(msg_v, 0);
    chk(st_v, 0);
    acc(0, 12'h1C9, 0); chk(rd, {61'h0, top});
    acc(0, 12'(64 + top), 0); chk(rd, stk[top]);
    acc(0, 12'h1E1, 0); chk(rd, {32'h0, last.source});
    // Trace messages, trace store, full interrupt and wrap.
    acc(1, 12'h1D9, 64'h1C0);
    acc(0, 12'h1D9, 0); chk(rd, 64'h1C0);
    ev(0);
    chk(msg_v, 1); chk(msg, sent);
    chk(st_v, 1); chk(st, sent);
    full_pulse;
    chk(irq, 1); chk(wrap, 0);
    acc(1, 12'h1D9, 64'h0C0);
    full_pulse;
    chk(irq, 0); chk(wrap, 1);
    // Report pins: breakpoints when selected, else performance events.
    acc(1, 12'h1D9, 64'h03C);
    r = 4'($urandom_range(15, 1));
    @(posedge clk) begin bp <= r; perf <= ~r; end
    @(posedge clk) begin bp <= 4'h0; perf <= 4'h0; end
    #1 chk(pins, 4'(~r));
    @(posedge clk) #1 chk(pins, 4'hF);
    acc(1, 12'h1D9, 64'h002);
    @(posedge clk) #1 chk(step, 1);
    @(posedge clk) begin bp <= r; perf <= ~r; end
    @(posedge clk) begin bp <= 4'h0; perf <= 4'h0; end
    #1 chk(pins, 4'(r));
    end_of_test;
  end
endmodule : last_branch_recorder_tb
`default_nettype wire
